// ### hw/ipfr_pkg.sv
package ipfr_pkg;

  // ==========================================================
  // Register addresses in the special-function space
  localparam logic [7:0] ADDR_EXT_IRQ_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_STD = 8'hB8;
  localparam logic [7:0] ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG = 8'hD8;
  localparam logic [7:0] ADDR_SPI_IRQ_SOURCE = 8'hE4;
  localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'hE8;
  localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY = 8'hF8;

  // ==========================================================
  // Field positions
  localparam int BIT_EXTERN0_FLAG = 5;
  localparam int BIT_CONVERTER_FLAG = 4;
  localparam int BIT_SERIAL1_BAUD_DOUBLER = 7;
  localparam int BIT_EXTERN_TWO_FLAG = 3;
  localparam int BIT_EXTERN_TWO = 4;
  localparam int BIT_EXTERN0 = 1;
  localparam int BIT_CONVERTER = 0;
  localparam int STD_PRIO_WIDTH = 7;

  // ==========================================================
  // Constant-one masks of reserved bits
  localparam logic [7:0] ONES_IRQ_PRIORITY_STD = 8'h80;
  localparam logic [7:0] ONES_EXT_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] ONES_SERIAL_DOUBLER = 8'h40;
  localparam logic [7:0] ONES_EXT_IRQ_ENABLE = 8'hE0;
  localparam logic [7:0] ONES_EXT_IRQ_PRIORITY = 8'hE0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================
  // Reset values of writable bits
  localparam logic [6:0] RST_IRQ_PRIORITY_STD = 7'h00;
  localparam logic [2:0] RST_EXT_CTRL = 3'h0;
  localparam logic RST_DOUBLER = 1'b0;

  // ==========================================================
  // Source numbers, in fixed arbitration order
  localparam int NUM_SOURCES = 10;
  localparam logic [3:0] SRC_SPI_PERIPH = 4'h0;
  localparam logic [3:0] SRC_EXTERN0 = 4'h8;
  localparam logic [3:0] SRC_EXTERN_TWO = 4'h9;
  localparam logic [3:0] SRC_CONVERTER = 4'h7;
  localparam logic [3:0] SRC_POWER_FAIL = 4'hA;

endpackage

// ### hw/ipfr_edge_flag.sv
`timescale 1ns/10ps
module ipfr_edge_flag #(
  parameter bit RISING = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic levelIn,
  input wire logic wrEn,
  input wire logic wrValue,
  output logic flag_q
);

  logic prev_q;
  logic edgeSeen;

  // ==========================================================
  // Edge detect, idle level assumed at reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      prev_q <= !RISING;
    else
      prev_q <= levelIn;
  end

  assign edgeSeen = RISING ? (levelIn & !prev_q) : (!levelIn & prev_q);

  // ==========================================================
  // Sticky flag, hardware set beats software clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (edgeSeen)
      flag_q <= 1'b1;
    else if (wrEn)
      flag_q <= wrValue;
  end

endmodule

// ### hw/ipfr_irq_regs.sv
`timescale 1ns/10ps
// Functional notes
// - Std priority bits 6..0, one per source
// - Listed reserved bits always read one
// - Other reserved bits always read zero
// - Extern0 falling edge sets sticky flag
// - Converter rising edge sets sticky flag
// - Software-set extended flag requests like hardware
// - Extern2 detection sets flag until cleared
// - Uncleared extern2 flag requests again after return
// - Software-set extern2 flag raises request
// - Control bit 7 doubles serial1 baud
// - Enable bit 4 gates extern2
// - Enable bit 1 gates extern0
// - Enable bit 0 gates converter
// - Extended priority bits 4,1,0 select level
// - Read-only SPI priority encoder readout
// - Global enable masks all but power-fail
// - Preemption only by strictly higher level
// - Extern0 low edge, extern2 high edge
module ipfr_irq_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData_q,
  input wire logic extern0_pin_n,
  input wire logic extern_two_pin,
  input wire logic converterIrqIn,
  input wire logic [7:0] spi_source_code,
  input wire logic [6:0] stdIrqPending,
  input wire logic [6:0] stdIrqEnable,
  input wire logic global_irq_enable,
  input wire logic powerFailIrq,
  input wire logic irqAck,
  input wire logic irqReturn,
  output logic irqReq_q,
  output logic [3:0] irqSource_q,
  output logic irqHigh_q,
  output logic serial1_baud_doubler
);
  import ipfr_pkg::*;

  // ==========================================================
  // Register state
  logic [6:0] irqPrioStd_q;
  logic extern_two_enable_q;
  logic extern0_enable_q;
  logic converter_enable_q;
  logic extern_two_prio_q;
  logic extern0_prio_q;
  logic converter_prio_q;
  logic doubler_q;
  logic [7:0] spiSource_q;
  logic extern0_flag;
  logic converter_flag;
  logic extern_two_flag;
  logic wrFlags;
  logic wrControl;
  logic wrPrioStd;
  logic wrEnable;
  logic wrPriority;

  // ==========================================================
  // Arbitration state
  logic inServiceLow_q;
  logic inServiceHigh_q;
  logic inServicePf_q;
  logic [NUM_SOURCES-1:0] rawReq;
  logic [NUM_SOURCES-1:0] enables;
  logic [NUM_SOURCES-1:0] prios;
  logic [NUM_SOURCES-1:0] pending;
  logic [NUM_SOURCES-1:0] highPend;
  logic [NUM_SOURCES-1:0] lowPend;
  logic reqGrant;
  logic [3:0] srcGrant;
  logic highGrant;

  // Nesting levels, ordered lowest first
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LEVEL_PF = 2'h2;

  // ==========================================================
  // Lowest set index wins
  function automatic logic [3:0] firstSet(input logic [NUM_SOURCES-1:0] vec);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--)
    begin
      if (vec[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_addr);
    return a == ref_addr;
  endfunction

  // ==========================================================
  // A level is free while nothing at or above it is in service
  function automatic logic levelFree(input logic [1:0] level, input logic pfBusy, input logic highBusy,
    input logic lowBusy);
    logic free;
    free = !pfBusy;
    if (level != LEVEL_PF)
      free = free && !highBusy;
    if (level == LEVEL_LOW)
      free = free && !lowBusy;
    return free;
  endfunction

  assign wrFlags = sfrWr && isAddr(sfrAddr, ADDR_EXT_IRQ_FLAGS);
  assign wrControl = sfrWr && isAddr(sfrAddr, ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG);
  assign wrPrioStd = sfrWr && isAddr(sfrAddr, ADDR_IRQ_PRIORITY_STD);
  assign wrEnable = sfrWr && isAddr(sfrAddr, ADDR_EXT_IRQ_ENABLE);
  assign wrPriority = sfrWr && isAddr(sfrAddr, ADDR_EXT_IRQ_PRIORITY);

  // ==========================================================
  // Standard priority register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irqPrioStd_q <= RST_IRQ_PRIORITY_STD;
    else if (wrPrioStd)
      irqPrioStd_q <= sfrWrData[STD_PRIO_WIDTH-1:0];
  end

  // ==========================================================
  // Extended enable register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      extern_two_enable_q <= RST_EXT_CTRL[2];
      extern0_enable_q <= RST_EXT_CTRL[1];
      converter_enable_q <= RST_EXT_CTRL[0];
    end
    else if (wrEnable)
    begin
      extern_two_enable_q <= sfrWrData[BIT_EXTERN_TWO];
      extern0_enable_q <= sfrWrData[BIT_EXTERN0];
      converter_enable_q <= sfrWrData[BIT_CONVERTER];
    end
  end

  // ==========================================================
  // Extended priority register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      extern_two_prio_q <= RST_EXT_CTRL[2];
      extern0_prio_q <= RST_EXT_CTRL[1];
      converter_prio_q <= RST_EXT_CTRL[0];
    end
    else if (wrPriority)
    begin
      extern_two_prio_q <= sfrWrData[BIT_EXTERN_TWO];
      extern0_prio_q <= sfrWrData[BIT_EXTERN0];
      converter_prio_q <= sfrWrData[BIT_CONVERTER];
    end
  end

  // ==========================================================
  // Baud doubler
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      doubler_q <= RST_DOUBLER;
    else if (wrControl)
      doubler_q <= sfrWrData[BIT_SERIAL1_BAUD_DOUBLER];
  end

  assign serial1_baud_doubler = doubler_q;

  // ==========================================================
  // SPI encoder readout, sampled each cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      spiSource_q <= 8'h00;
    else
      spiSource_q <= spi_source_code;
  end

  // ==========================================================
  // Sticky extended flags
  // A software one sets a flag as a pin event would
  // Extern0 pin idles high, reacts to falling edge
  ipfr_edge_flag #(
    .RISING(1'b0)
  ) u_extern0_flag (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .levelIn(extern0_pin_n),
    .wrEn(wrFlags),
    .wrValue(sfrWrData[BIT_EXTERN0_FLAG]),
    .flag_q(extern0_flag)
  );

  // Converter input reacts to rising edge
  ipfr_edge_flag #(
    .RISING(1'b1)
  ) u_converter_flag (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .levelIn(converterIrqIn),
    .wrEn(wrFlags),
    .wrValue(sfrWrData[BIT_CONVERTER_FLAG]),
    .flag_q(converter_flag)
  );

  // Extern2 pin active high, edge only
  ipfr_edge_flag #(
    .RISING(1'b1)
  ) u_extern_two_flag (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .levelIn(extern_two_pin),
    .wrEn(wrControl),
    .wrValue(sfrWrData[BIT_EXTERN_TWO_FLAG]),
    .flag_q(extern_two_flag)
  );

  // ==========================================================
  // Register read port
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sfrRdData_q <= READ_UNMAPPED;
    else if (sfrRd)
    begin
      case (sfrAddr)
        ADDR_IRQ_PRIORITY_STD:
          sfrRdData_q <= ONES_IRQ_PRIORITY_STD | {1'b0, irqPrioStd_q};
        ADDR_EXT_IRQ_FLAGS:
          sfrRdData_q <= ONES_EXT_IRQ_FLAGS | {2'b00, extern0_flag, converter_flag, 4'h0};
        ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG:
          sfrRdData_q <= ONES_SERIAL_DOUBLER | {doubler_q, 3'b000, extern_two_flag, 3'b000};
        ADDR_SPI_IRQ_SOURCE:
          sfrRdData_q <= spiSource_q;
        ADDR_EXT_IRQ_ENABLE:
          sfrRdData_q <= ONES_EXT_IRQ_ENABLE |
            {3'b000, extern_two_enable_q, 2'b00, extern0_enable_q, converter_enable_q};
        ADDR_EXT_IRQ_PRIORITY:
          sfrRdData_q <= ONES_EXT_IRQ_PRIORITY |
            {3'b000, extern_two_prio_q, 2'b00, extern0_prio_q, converter_prio_q};
        default:
          sfrRdData_q <= READ_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Request vectors, index is arbitration order
  // Flags are levels: a flag left set requests again
  assign rawReq = {extern_two_flag, extern0_flag, converter_flag, stdIrqPending};
  assign enables = {extern_two_enable_q, extern0_enable_q, converter_enable_q, stdIrqEnable};
  assign prios = {extern_two_prio_q, extern0_prio_q, converter_prio_q, irqPrioStd_q};
  assign pending = global_irq_enable ? (rawReq & enables) : '0;
  assign highPend = pending & prios;
  assign lowPend = pending & ~prios;

  // ==========================================================
  // Grant selection
  always_comb
  begin
    reqGrant = 1'b0;
    srcGrant = SRC_SPI_PERIPH;
    highGrant = 1'b0;
    if (powerFailIrq && levelFree(LEVEL_PF, inServicePf_q, inServiceHigh_q, inServiceLow_q))
    begin
      reqGrant = 1'b1;
      srcGrant = SRC_POWER_FAIL;
      highGrant = 1'b1;
    end
    else if (|highPend && levelFree(LEVEL_HIGH, inServicePf_q, inServiceHigh_q, inServiceLow_q))
    begin
      reqGrant = 1'b1;
      srcGrant = firstSet(highPend);
      highGrant = 1'b1;
    end
    else if (|lowPend && levelFree(LEVEL_LOW, inServicePf_q, inServiceHigh_q, inServiceLow_q))
    begin
      reqGrant = 1'b1;
      srcGrant = firstSet(lowPend);
      highGrant = 1'b0;
    end
  end

  // ==========================================================
  // Request output, withdrawn at the edge that ends the acknowledge cycle
  // Keeps one request from being taken twice
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irqReq_q <= 1'b0;
      irqSource_q <= SRC_SPI_PERIPH;
      irqHigh_q <= 1'b0;
    end
    else
    begin
      irqReq_q <= reqGrant && !irqAck && !irqReturn;
      irqSource_q <= srcGrant;
      irqHigh_q <= highGrant;
    end
  end

  // ==========================================================
  // In-service levels, return pops the highest
  // Nesting runs low, high, power-fail, so the top is last
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      inServiceLow_q <= 1'b0;
      inServiceHigh_q <= 1'b0;
      inServicePf_q <= 1'b0;
    end
    else if (irqAck && irqReq_q)
    begin
      if (irqSource_q == SRC_POWER_FAIL)
        inServicePf_q <= 1'b1;
      else if (irqHigh_q)
        inServiceHigh_q <= 1'b1;
      else
        inServiceLow_q <= 1'b1;
    end
    else if (irqReturn)
    begin
      if (inServicePf_q)
        inServicePf_q <= 1'b0;
      else if (inServiceHigh_q)
        inServiceHigh_q <= 1'b0;
      else
        inServiceLow_q <= 1'b0;
    end
  end

endmodule

// ### bench/ipfr_cpu_model.sv
`timescale 1ns/10ps
// ==========
// CPU side: accepts a request, returns later
module ipfr_cpu_model (
  input wire logic clk_sys,
  input wire logic irqReq_q,
  input wire logic [3:0] irqSource_q,
  input wire logic irqHigh_q,
  input wire logic [3:0] ackWait,
  output logic irqAck,
  output logic irqReturn,
  output logic [3:0] lastSrc,
  output logic lastHigh,
  output int ackCount
);
  initial
  begin
    irqAck = 1'b0;
    irqReturn = 1'b0;
    lastSrc = '0;
    lastHigh = 1'b0;
    ackCount = 0;
    forever
    begin
      @(negedge clk_sys);
      if (irqReq_q === 1'b1)
      begin
        repeat (ackWait) @(negedge clk_sys);
        irqAck = 1'b1;
        lastSrc = irqSource_q;
        lastHigh = irqHigh_q;
        ackCount++;
        @(negedge clk_sys);
        irqAck = 1'b0;
        repeat (6) @(negedge clk_sys);
        irqReturn = 1'b1;
        @(negedge clk_sys);
        irqReturn = 1'b0;
      end
    end
  end
endmodule

// ### bench/ipfr_irq_regs_chk.sv
`timescale 1ns/10ps
module ipfr_irq_regs_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdData_q,
  input wire logic [6:0] stdIrqPending,
  input wire logic [6:0] stdIrqEnable,
  input wire logic global_irq_enable,
  input wire logic irqAck,
  input wire logic irqReturn,
  input wire logic irqReq_q,
  input wire logic [3:0] irqSource_q,
  input wire logic irqHigh_q,
  input wire logic serial1_baud_doubler
);
  import ipfr_pkg::*;
  logic [6:0] stdLive_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys)
  begin
    stdLive_q <= stdIrqPending & stdIrqEnable;
  end
  // ==========
  // Assertions
  a_rsvd_prio_ones: assert property (sfrRd && sfrAddr == ADDR_EXT_IRQ_PRIORITY
    |=> sfrRdData_q[7:5] == 3'h7) else $error("reserved priority bits not one");
  a_rsvd_flag_bits: assert property (sfrRd && sfrAddr == ADDR_EXT_IRQ_FLAGS
    |=> sfrRdData_q[3:0] == 4'h8) else $error("reserved flag bits wrong");
  a_rdata_hold: assert property (!sfrRd |=> $stable(sfrRdData_q)) else $error("read data moved");
  a_global_gate: assert property ($rose(irqReq_q) && irqSource_q != SRC_POWER_FAIL
    |-> $past(global_irq_enable)) else $error("request while globally masked");
  a_std_cause: assert property ($rose(irqReq_q) && irqSource_q < SRC_CONVERTER
    |-> stdLive_q[irqSource_q[2:0]]) else $error("std request without cause");
  a_ack_drops: assert property (irqAck && irqReq_q |=> !irqReq_q) else $error("request kept after ack");
  a_return_drops: assert property (irqReturn |=> !irqReq_q) else $error("request kept at return");
  a_pf_high: assert property (irqReq_q && irqSource_q == SRC_POWER_FAIL
    |-> irqHigh_q) else $error("power fail not high");
  a_doubler_write: assert property (sfrWr && sfrAddr == ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG
    |=> serial1_baud_doubler == $past(sfrWrData[7])) else $error("doubler not written");
  a_doubler_hold: assert property (!(sfrWr && sfrAddr == ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG)
    |=> $stable(serial1_baud_doubler)) else $error("doubler moved");
  c_extern_two_flag_ack: cover property (irqAck && irqSource_q == SRC_EXTERN_TWO);
  c_high_req: cover property (irqReq_q && irqHigh_q);
  c_pf_req: cover property (irqReq_q && irqSource_q == SRC_POWER_FAIL);
endmodule
bind ipfr_irq_regs ipfr_irq_regs_chk i_ipfr_irq_regs_chk (.clk_sys, .rst_n, .sfrAddr, .sfrWrData,
  .sfrWr, .sfrRd, .sfrRdData_q, .stdIrqPending, .stdIrqEnable, .global_irq_enable, .irqAck,
  .irqReturn, .irqReq_q, .irqSource_q, .irqHigh_q, .serial1_baud_doubler);

// ### bench/tb_ipfr_irq_regs.sv
`timescale 1ns/10ps
module tb_ipfr_irq_regs;
  import ipfr_pkg::*;
  logic clk_sys, rst_n, sfrWr, sfrRd, extern0_pin_n, extern_two_pin, converterIrqIn;
  logic global_irq_enable, powerFailIrq, irqAck, irqReturn, irqReq_q, irqHigh_q;
  logic serial1_baud_doubler, dbl, f0, fc, f2, lastHigh;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData_q, spi_source_code, pr, en, ep, ta;
  logic [6:0] stdIrqPending, stdIrqEnable;
  logic [3:0] irqSource_q, lastSrc, ackWait;
  logic [7:0] tbl [6] = '{8'hB8, 8'hE8, 8'hF8, 8'hD8, 8'hE4, 8'h92};
  logic [3:0] srcT [3] = '{SRC_EXTERN0, SRC_CONVERTER, SRC_EXTERN_TWO};
  logic [7:0] faT [3] = '{8'h91, 8'h91, 8'hD8};
  logic [7:0] fvT [3] = '{8'h20, 8'h10, 8'h08};
  logic [7:0] enT [3] = '{8'h02, 8'h01, 8'h10};
  int ackCount, mismatches = 0, checks_done = 0;
  ipfr_irq_regs i_ipfr_irq_regs (.clk_sys, .rst_n, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd,
    .sfrRdData_q, .extern0_pin_n, .extern_two_pin, .converterIrqIn, .spi_source_code,
    .stdIrqPending, .stdIrqEnable, .global_irq_enable, .powerFailIrq, .irqAck, .irqReturn,
    .irqReq_q, .irqSource_q, .irqHigh_q, .serial1_baud_doubler);
  ipfr_cpu_model i_ipfr_cpu_model (.clk_sys, .irqReq_q, .irqSource_q, .irqHigh_q, .ackWait, .irqAck,
    .irqReturn, .lastSrc, .lastHigh, .ackCount);
  initial
  begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========
  // Bench model and bus tasks
  function automatic logic [7:0] expv(logic [7:0] a);
    case (a)
      ADDR_IRQ_PRIORITY_STD: return 8'h80 | pr;
      ADDR_EXT_IRQ_FLAGS: return {2'h0, f0, fc, 4'h8};
      ADDR_SERIAL_DOUBLER_AND_IRQ2_FLAG: return {dbl, 1'b1, 2'h0, f2, 3'h0};
      ADDR_SPI_IRQ_SOURCE: return spi_source_code;
      ADDR_EXT_IRQ_ENABLE: return 8'hE0 | en;
      ADDR_EXT_IRQ_PRIORITY: return 8'hE0 | ep;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic expHigh(logic [3:0] s);
    case (s)
      SRC_POWER_FAIL: return 1'b1;
      SRC_EXTERN_TWO: return ep[4];
      SRC_EXTERN0: return ep[1];
      SRC_CONVERTER: return ep[0];
      default: return pr[s[2:0]];
    endcase
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    @(negedge clk_sys);
    sfrWr = 1'b0;
    case (a)
      8'hB8: pr = d & 8'h7F;
      8'hE8: en = d & 8'h13;
      8'hF8: ep = d & 8'h13;
      8'hD8: {dbl, f2} = {d[7], d[3]};
      8'h91: {f0, fc} = d[5:4];
      default: ;
    endcase
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge clk_sys);
    sfrRd = 1'b0;
    chk("read data", expv(a), sfrRdData_q);
  endtask
  task automatic req(logic [3:0] s);
    int c0;
    c0 = ackCount;
    repeat (30) if (ackCount == c0) @(negedge clk_sys);
    chk("source", {4'h0, s}, {4'h0, lastSrc});
    chk("ack count", 8'(c0 + 1), ackCount[7:0]);
    chk("priority level", {7'h0, expHigh(s)}, {7'h0, lastHigh});
  endtask
  task automatic noReq(int n);
    int c0;
    c0 = ackCount;
    repeat (n) @(negedge clk_sys);
    chk("no request", c0[7:0], ackCount[7:0]);
  endtask
  task automatic fire(int i);
    @(negedge clk_sys);
    if (i == 0) {extern0_pin_n, f0} = 2'b01;
    else if (i == 1) {converterIrqIn, fc} = 2'b11;
    else {extern_two_pin, f2} = 2'b11;
    repeat (2) @(negedge clk_sys);
    {extern0_pin_n, converterIrqIn, extern_two_pin} = 3'b100;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    test_done();
  end
  // ==========
  // Tests
  initial
  begin
    {rst_n, sfrWr, sfrRd, extern_two_pin, converterIrqIn, global_irq_enable, powerFailIrq} = 0;
    {sfrAddr, sfrWrData, spi_source_code, stdIrqPending, stdIrqEnable, ackWait} = 0;
    extern0_pin_n = 1'b1;
    {pr, en, ep, dbl, f0, fc, f2} = '0;
    void'($urandom(6492));
    repeat (20) @(negedge clk_sys);
    rst_n = 1;
    rd(8'h91);
    foreach (tbl[i]) rd(tbl[i]);
    $display("reset values done");
    repeat (24)
    begin
      ta = tbl[$urandom % 6];
      spi_source_code = 8'($urandom);
      wr(ta, 8'($urandom));
      rd(ta);
      chk("doubler", {7'h0, dbl}, {7'h0, serial1_baud_doubler});
    end
    wr(8'hD8, 8'h00);
    wr(8'h91, 8'h00);
    wr(8'hF8, 8'h00);
    $display("register access done");
    global_irq_enable = 1;
    wr(8'hE8, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      fire(i);
      noReq(8);
      rd(faT[i]);
      wr(8'hE8, enT[i]);
      req(srcT[i]);
      wr(faT[i], 8'h00);
      noReq(12);
      wr(faT[i], fvT[i]);
      req(srcT[i]);
      wr(faT[i], 8'h00);
      wr(8'hE8, 8'h00);
    end
    $display("event sources done");
    wr(8'hE8, 8'h13);
    wr(8'h91, 8'h30);
    req(SRC_CONVERTER);
    wr(8'h91, 8'h20);
    req(SRC_EXTERN0);
    wr(8'h91, 8'h00);
    wr(8'hF8, 8'h02);
    wr(8'h91, 8'h30);
    req(SRC_EXTERN0);
    wr(8'h91, 8'h10);
    req(SRC_CONVERTER);
    wr(8'h91, 8'h00);
    wr(8'hF8, 8'h00);
    $display("priority order done");
    ackWait = 4'h5;
    wr(8'hD8, 8'h08);
    req(SRC_EXTERN_TWO);
    req(SRC_EXTERN_TWO);
    wr(8'hD8, 8'h00);
    noReq(20);
    ackWait = 4'h0;
    $display("re-request done");
    stdIrqEnable = 7'h7F;
    wr(8'hB8, 8'h04);
    stdIrqPending = 7'h06;
    req(4'h2);
    stdIrqPending = 7'h02;
    req(4'h1);
    stdIrqPending = 7'h00;
    global_irq_enable = 0;
    stdIrqPending = 7'h01;
    noReq(12);
    powerFailIrq = 1;
    req(SRC_POWER_FAIL);
    {powerFailIrq, stdIrqPending} = 0;
    noReq(12);
    $display("masking done");
    test_done();
  end
endmodule
